//--- rtl/fpa_pkg.sv
package fpa_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_MSR   = 8'h04;
  localparam logic [7:0] OFF_FP_STATUS_CONTROL_REG = 8'h08;
  localparam logic [7:0] OFF_SAVE_RESTORE_PC  = 8'h0C;
  localparam logic [7:0] OFF_SAVE_RESTORE_STATE  = 8'h10;

  // ----------------------------------------------------------------
  // field positions, bus bit 31 is the architectural bit 0
  // ----------------------------------------------------------------
  localparam int MSR_LE    = 0;
  localparam int MSR_IP    = 6;
  localparam int MSR_FE1   = 8;
  localparam int MSR_FE0   = 11;
  localparam int MSR_ME    = 12;
  localparam int MSR_ILE   = 16;
  localparam int FS_FX     = 31;
  localparam int FS_FEX    = 30;
  localparam int FS_FLG_HI = 29;   // VX OX UX ZX XX
  localparam int FS_FLG_LO = 25;
  localparam int FS_UX     = 27;
  localparam int FS_EN_HI  = 7;    // VE OE UE ZE XE
  localparam int FS_EN_LO  = 3;
  localparam int FS_UE     = 5;
  localparam int CA_SIE    = 31;
  localparam int CA_DNC    = 3;
  localparam int CA_DNB    = 2;
  localparam int CA_DNA    = 1;
  localparam int CA_TR     = 0;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [31:0] MSR_RST   = 32'h0000_0000;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_RST = 32'h0000_0000;
  localparam logic [31:0] CAUSE_RST = 32'h0000_0000;
  localparam logic [31:0] VEC_OFF   = 32'h0000_0E00;
  localparam logic [10:0] EXP_ADJ_S = 11'h0C0;  // 192
  localparam logic [10:0] EXP_ADJ_D = 11'h600;  // 1536
  localparam int          EXC_W     = 5;

  // instruction classes seen by the exception logic
  typedef enum logic [2:0] {
    CL_LD_S  = 3'h0,
    CL_LD_D  = 3'h1,
    CL_ST_S  = 3'h3,
    CL_ST_D  = 3'h2,
    CL_AR_S  = 3'h6,
    CL_AR_D  = 3'h7,
    CL_RND_S = 3'h5,
    CL_OTHER = 3'h4
  } fpa_class_e;

  // operand magnitude range, normal when not denormalized
  typedef enum logic [2:0] {
    RNG_NORM = 3'h0,
    RNG_B    = 3'h1,
    RNG_C    = 3'h3,
    RNG_D    = 3'h2,
    RNG_E    = 3'h6,
    RNG_F    = 3'h7
  } fpa_rng_e;

endpackage : fpa_pkg

//--- rtl/fpa_assist_exc.sv
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Functional notes
// [RULE_01] enabled FP exception with either mode bit set raises assist
// [RULE_02] condition made true by register write or return gives program
// [RULE_03] tiny result with underflow disabled raises assist
// [RULE_04] some denormal operands the hardware cannot handle raise assist
// [RULE_05] assist saves faulting instruction address in save_restore_pc
// [RULE_06] save_restore_state upper half cleared, lower half from state
// [RULE_07] state keeps vector select and check enable, endian from EXCEPTION_ENDIAN_MODE
// [RULE_08] fetch continues at vector base plus 0x00E00
// [RULE_09] denormal partitioning per instruction class and range
// [RULE_10] single op on double operand correct only if low bits zero
// [RULE_11] round-to-single tiny from denormal takes assist at end
// [RULE_12] programming error cases give boundedly undefined results
// [RULE_13] sync-ignore mode applies only to FPU, not load/store unit
// [RULE_14] sync-ignore re-execution raises no second assist
// [RULE_15] sync-ignore gives default results, updates status and cause
// [RULE_16] cause register holds four flags and the sync-ignore bit
// [RULE_17] sync-ignore op making condition true takes program exception
// [RULE_18] handler clears both mode bits before sync-ignore execution
// [RULE_19] return restores state; program exception if condition true
// [RULE_20] tiny sync-ignore result exponent plus 192 or 1536
// [RULE_21] handler itself sets the underflow flag for tiny results
// [RULE_22] unhandled denormal leaves the destination register unchanged
// [RULE_23] cause bits: sync-ignore bit 0, OPERAND_C_DENORMAL_FLAG OPERAND_B_DENORMAL_FLAG OPERAND_A_DENORMAL_FLAG TR at 28..31
// [RULE_24] summary is OR of each flag ANDed with its enable
// [RULE_25] assist only without a higher priority exception pending
module fpa_assist_exc #(
  parameter int          EXP_W   = 11,
  parameter logic [31:0] BASE_LO = 32'h0000_0000,
  parameter logic [31:0] BASE_HI = 32'hFFF0_0000
) (
  // clock, reset, enable
  input  wire  logic                 hclk,
  input  wire  logic                 hresetn,
  input  wire  logic                 hce,
  // ahb-lite slave
  input  wire  logic                 hsel,
  input  wire  logic [31:0]          haddr,
  input  wire  logic [1:0]           htrans,
  input  wire  logic                 hwrite,
  input  wire  logic [2:0]           hsize,
  input  wire  logic [31:0]          hwdata,
  input  wire  logic                 hready,
  output logic       [31:0]          hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // instruction from the core
  input  wire  logic                 ins_valid,
  input  wire  logic [31:0]          ins_ea,
  input  wire  fpa_pkg::fpa_class_e  ins_class,
  input  wire  fpa_pkg::fpa_rng_e    ins_rng_a,
  input  wire  fpa_pkg::fpa_rng_e    ins_rng_b,
  input  wire  fpa_pkg::fpa_rng_e    ins_rng_c,
  input  wire  logic [2:0]           ins_low_nz,
  input  wire  logic                 ins_tiny,
  input  wire  logic                 ins_dp,
  input  wire  logic [4:0]           ins_exc_set,
  input  wire  logic                 ins_hi_prio,
  input  wire  logic [EXP_W-1:0]     ins_res_exp,
  input  wire  logic                 rfi_valid,
  // results to the core
  output logic                       assist_take,
  output logic                       prog_take,
  output logic [31:0]                fetch_addr,
  output logic                       dest_we,
  output logic [EXP_W-1:0]           res_exp_out,
  output logic                       undef_result,
  output logic [31:0]                machine_state_out
);
  import fpa_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]      machine_state_reg_r;
  logic [31:0]      fp_status_control_reg_r;
  logic [31:0]      fp_exc_cause_reg_r;
  logic [31:0]      save_restore_pc_r;
  logic [31:0]      save_restore_state_r;
  logic             bus_wr_r;
  logic [7:0]       bus_addr_r;
  logic [31:0]      hrdata_r;
  logic             prog_chk_r;
  logic             assist_r;
  logic             prog_r;
  logic [31:0]      fetch_r;
  logic             dest_we_r;
  logic [EXP_W-1:0] exp_r;
  logic             undef_r;

  // ----------------------------------------------------------------
  // per-operand denormal classification
  // ----------------------------------------------------------------
  fpa_rng_e   rng [3];
  logic [2:0] need_dn;
  logic [2:0] perr;
  logic [2:0] rs_cd;
  logic [2:0] is_dn;

  assign rng[0] = ins_rng_a;
  assign rng[1] = ins_rng_b;
  assign rng[2] = ins_rng_c;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_opnd
      // operand range against instruction class
      always_comb begin
        is_dn[gi]   = (rng[gi] != RNG_NORM);
        need_dn[gi] = 1'b0;
        perr[gi]    = 1'b0;
        rs_cd[gi]   = 1'b0;
        unique case (ins_class)
          CL_LD_S, CL_ST_S: begin
            need_dn[gi] = (rng[gi] == RNG_D);  // RULE_09
            if (ins_class == CL_ST_S) begin
              perr[gi] = (rng[gi] == RNG_B) || (rng[gi] == RNG_C) ||
                         (rng[gi] == RNG_F) ||
                         ((rng[gi] == RNG_E) && ins_low_nz[gi]);  // RULE_10
            end
          end
          CL_AR_S: begin
            perr[gi] = (rng[gi] == RNG_B) || (rng[gi] == RNG_C) ||
                       (rng[gi] == RNG_F) ||
                       (((rng[gi] == RNG_D) || (rng[gi] == RNG_E)) &&
                        ins_low_nz[gi]);  // RULE_10
          end
          CL_AR_D: need_dn[gi] = (rng[gi] == RNG_B);  // RULE_09
          CL_RND_S: begin
            need_dn[gi] = (rng[gi] == RNG_B);  // RULE_09
            rs_cd[gi]   = (rng[gi] == RNG_C) || (rng[gi] == RNG_D);
          end
          CL_LD_D, CL_ST_D, CL_OTHER: need_dn[gi] = 1'b0;  // RULE_09
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // exception decision for the presented instruction
  // ----------------------------------------------------------------
  logic        ins_go;
  logic        go_ok;
  logic        is_lsu;
  logic        sie_eff;
  logic        mode_fe;
  logic        ue;
  logic        a_dn;
  logic        a_tiny;
  logic        a_en;
  logic        take;
  logic        fp_upd;
  logic [31:0] set_bits;
  logic [31:0] fp_status_control_reg_upd;
  logic        fex_upd;
  logic        fex_cur;
  logic        sie_op;

  assign ins_go  = hce && ins_valid;
  assign go_ok   = ins_go && !ins_hi_prio;
  assign is_lsu  = (ins_class == CL_LD_S) || (ins_class == CL_LD_D) ||
                   (ins_class == CL_ST_S) || (ins_class == CL_ST_D);
  assign sie_eff = fp_exc_cause_reg_r[CA_SIE] && !is_lsu;  // RULE_13
  assign mode_fe = machine_state_reg_r[MSR_FE0] ||
                   machine_state_reg_r[MSR_FE1];
  assign ue      = fp_status_control_reg_r[FS_UE];

  // flags raised by the op; underflow flag left to the handler when tiny with underflow disabled
  always_comb begin
    set_bits = 32'h0000_0000;
    set_bits[FS_FLG_HI:FS_FLG_LO] = ins_exc_set;
    if (ins_tiny && !ue) begin
      set_bits[FS_UX] = 1'b0;  // RULE_21
    end
    set_bits[FS_FX] = |(set_bits & ~fp_status_control_reg_r);
  end

  assign fp_status_control_reg_upd = fp_status_control_reg_r | set_bits;
  // summary of enabled exceptions
  assign fex_upd = |(fp_status_control_reg_upd[FS_FLG_HI:FS_FLG_LO] &
                     fp_status_control_reg_upd[FS_EN_HI:FS_EN_LO]);  // RULE_24
  assign fex_cur = |(fp_status_control_reg_r[FS_FLG_HI:FS_FLG_LO] &
                     fp_status_control_reg_r[FS_EN_HI:FS_EN_LO]);  // RULE_24

  // sync-ignore suppresses every assist cause except for load/store instructions
  assign a_dn   = !sie_eff && (|need_dn);  // RULE_04 RULE_14
  assign a_tiny = !sie_eff && ins_tiny &&
                  (!ue || (ins_class == CL_RND_S && |rs_cd));  // RULE_03 RULE_11
  assign a_en   = !sie_eff && mode_fe && fex_upd;  // RULE_01
  assign take   = go_ok && (a_dn || a_tiny || a_en);  // RULE_25
  assign fp_upd = go_ok && (!take || (a_en && !a_dn));  // RULE_15
  assign sie_op = go_ok && sie_eff;

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  logic        acc;
  logic        wr_cause;
  logic        wr_msr;
  logic        wr_fp_status_control_reg;
  logic        wr_save_restore_pc;
  logic        wr_save_restore_state;
  logic [31:0] rd_mux;

  assign acc      = hsel && hready && htrans[1];
  assign wr_cause = hce && bus_wr_r && (bus_addr_r == OFF_CAUSE);
  assign wr_msr   = hce && bus_wr_r && (bus_addr_r == OFF_MSR);
  assign wr_fp_status_control_reg = hce && bus_wr_r && (bus_addr_r == OFF_FP_STATUS_CONTROL_REG);
  assign wr_save_restore_pc  = hce && bus_wr_r && (bus_addr_r == OFF_SAVE_RESTORE_PC);
  assign wr_save_restore_state  = hce && bus_wr_r && (bus_addr_r == OFF_SAVE_RESTORE_STATE);

  // read data chosen in the address phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_CAUSE: rd_mux = fp_exc_cause_reg_r;
      OFF_MSR:   rd_mux = machine_state_reg_r;
      OFF_FP_STATUS_CONTROL_REG: begin
        rd_mux         = fp_status_control_reg_r;
        rd_mux[FS_FEX] = fex_cur;
      end
      OFF_SAVE_RESTORE_PC:  rd_mux = save_restore_pc_r;
      OFF_SAVE_RESTORE_STATE:  rd_mux = save_restore_state_r;
      default:   rd_mux = 32'h0000_0000;  // unmapped reads zero
    endcase
  end

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_r   <= 1'b0;
      bus_addr_r <= 8'h00;
      hrdata_r   <= 32'h0000_0000;
    end else if (hce) begin
      bus_wr_r   <= acc && hwrite;
      bus_addr_r <= haddr[7:0];
      if (acc && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // machine state and save/restore registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      machine_state_reg_r <= MSR_RST;
    end else if (hce) begin
      if (take) begin
        machine_state_reg_r         <= 32'h0000_0000;  // RULE_07
        machine_state_reg_r[MSR_IP] <= machine_state_reg_r[MSR_IP];
        machine_state_reg_r[MSR_ME] <= machine_state_reg_r[MSR_ME];
        machine_state_reg_r[MSR_LE] <= machine_state_reg_r[MSR_ILE];
      end else if (rfi_valid) begin
        machine_state_reg_r <= save_restore_state_r;  // RULE_19
      end else if (wr_msr) begin
        machine_state_reg_r <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      save_restore_pc_r    <= 32'h0000_0000;
      save_restore_state_r <= 32'h0000_0000;
    end else if (hce) begin
      if (take) begin
        save_restore_pc_r    <= ins_ea;  // RULE_05
        save_restore_state_r <= {16'h0000,
                                 machine_state_reg_r[15:0]};  // RULE_06
      end else begin
        if (wr_save_restore_pc) begin
          save_restore_pc_r <= hwdata;
        end
        if (wr_save_restore_state) begin
          save_restore_state_r <= hwdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status and cause registers, hardware update wins over software
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_status_control_reg_r <= FP_STATUS_CONTROL_REG_RST;
    end else if (hce) begin
      if (fp_upd) begin
        fp_status_control_reg_r <= (wr_fp_status_control_reg ? hwdata :
                                    fp_status_control_reg_r) |
                                   set_bits;  // RULE_15
        fp_status_control_reg_r[FS_FEX] <= 1'b0;
      end else if (wr_fp_status_control_reg) begin
        fp_status_control_reg_r         <= hwdata;
        fp_status_control_reg_r[FS_FEX] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fp_exc_cause_reg_r <= CAUSE_RST;  // RULE_23
    end else if (hce) begin
      if (wr_cause) begin
        fp_exc_cause_reg_r         <= 32'h0000_0000;
        fp_exc_cause_reg_r[CA_SIE] <= hwdata[CA_SIE];  // RULE_16
        fp_exc_cause_reg_r[CA_DNC:CA_TR] <= hwdata[CA_DNC:CA_TR];
      end
      if (sie_op) begin
        fp_exc_cause_reg_r[CA_DNC] <= is_dn[2];  // RULE_15 RULE_23
        fp_exc_cause_reg_r[CA_DNB] <= is_dn[1];
        fp_exc_cause_reg_r[CA_DNA] <= is_dn[0];
        fp_exc_cause_reg_r[CA_TR]  <= ins_tiny;
      end
    end
  end

  // ----------------------------------------------------------------
  // program exception check, one cycle after the causing update
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_chk_r <= 1'b0;
      prog_r     <= 1'b0;
    end else if (hce) begin
      prog_chk_r <= wr_msr || wr_fp_status_control_reg || rfi_valid ||
                    sie_op;  // RULE_02 RULE_17 RULE_19
      prog_r     <= prog_chk_r && mode_fe && fex_cur;  // RULE_02 RULE_17
    end
  end

  // ----------------------------------------------------------------
  // results toward the core
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      assist_r  <= 1'b0;
      fetch_r   <= 32'h0000_0000;
      dest_we_r <= 1'b0;
      exp_r     <= '0;
      undef_r   <= 1'b0;
    end else if (hce) begin
      assist_r  <= take;
      if (take) begin
        fetch_r <= (machine_state_reg_r[MSR_IP] ? BASE_HI : BASE_LO) +
                   VEC_OFF;  // RULE_08
      end
      dest_we_r <= fp_upd && !(|need_dn);  // RULE_22
      undef_r   <= go_ok && (|perr);  // RULE_12
      if (sie_op && ins_tiny && !ue) begin
        exp_r <= ins_res_exp + EXP_W'(ins_dp ? EXP_ADJ_D :
                                                EXP_ADJ_S);  // RULE_20
      end else begin
        exp_r <= ins_res_exp;
      end
    end
  end

  assign hrdata            = hrdata_r;
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign assist_take       = assist_r;
  assign prog_take         = prog_r;
  assign fetch_addr        = fetch_r;
  assign dest_we           = dest_we_r;
  assign res_exp_out       = exp_r;
  assign undef_result      = undef_r;
  assign machine_state_out = machine_state_reg_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  enabled_assist_a: assert property (go_ok && !sie_eff && mode_fe &&  // RULE_01
    fex_upd |=> assist_take)
    else $error("enabled exception did not raise assist");
  tiny_assist_a: assert property (go_ok && !sie_eff && ins_tiny &&  // RULE_03
    !ue |=> assist_take)
    else $error("tiny result did not raise assist");
  lsu_no_sie_a: assert property (go_ok && is_lsu &&  // RULE_13
    fp_exc_cause_reg_r[CA_SIE] && (|need_dn) |=> assist_take)
    else $error("load/store denormal missed assist in sync mode");
  sie_no_assist_a: assert property (ins_go && sie_eff |=>  // RULE_14
    !assist_take)
    else $error("assist raised in sync-ignore mode");
  save_pc_a: assert property (take |=>  // RULE_05
    save_restore_pc_r == $past(ins_ea))
    else $error("saved pc differs from instruction address");
  save_state_a: assert property (take |=>  // RULE_06
    save_restore_state_r == {16'h0000, $past(machine_state_reg_r[15:0])})
    else $error("saved state wrong");
  state_endian_a: assert property (take |=>  // RULE_07
    machine_state_reg_r[MSR_LE] == $past(machine_state_reg_r[MSR_ILE]) &&
    !machine_state_reg_r[MSR_FE0] && !machine_state_reg_r[MSR_FE1])
    else $error("state not set correctly on assist");
  vector_addr_a: assert property (assist_take |->  // RULE_08
    fetch_addr == (machine_state_reg_r[MSR_IP] ? BASE_HI : BASE_LO) +
    VEC_OFF)
    else $error("assist fetch address wrong");
  rfi_restore_a: assert property (hce && rfi_valid && !take |=>  // RULE_19
    machine_state_reg_r == $past(save_restore_state_r))
    else $error("return did not restore state");
  rfi_prog_a: assert property (hce && rfi_valid && !take ##1  // RULE_19
    hce && mode_fe && fex_cur |=> prog_take)
    else $error("no program exception after return");
  exp_adjust_a: assert property (sie_op && ins_tiny && !ue &&  // RULE_20
    !ins_dp |=> res_exp_out == $past(ins_res_exp) + EXP_W'(EXP_ADJ_S))
    else $error("single tiny exponent not adjusted");
  dest_keep_a: assert property (ins_go && (|need_dn) |=>  // RULE_22
    !dest_we)
    else $error("destination written for denormal operand");
  hi_prio_a: assert property (ins_go && ins_hi_prio |=>  // RULE_25
    !assist_take)
    else $error("assist taken under higher priority");

  assist_seen_c: cover property (take ##1 assist_take);
  sie_prog_c:    cover property (sie_op ##2 prog_take);
  rfi_seen_c:    cover property (hce && rfi_valid ##1 !prog_take);
  bus_write_c:   cover property (wr_msr ##2 prog_take);

endmodule // fpa_assist_exc

//--- verification/fpa_assist_exc_tb.sv
`timescale 1ns/100ps
module fpa_assist_exc_tb;
  import fpa_pkg::*;
  // ----------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_HI_T = 32'hFFF0_0000;
  typedef struct packed {
    fpa_class_e c;
    fpa_rng_e   r;
    logic       lz, tn, ast, und;
  } fpa_row_s;
  logic        hclk, hresetn = 1'h0, hready, hreadyout, hresp;
  logic        hsel = 1'h0, hwrite = 1'h0, rfi_valid = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, ins_ea = 32'h0;
  logic [31:0] hrdata, fetch_addr, msr_out, rd, ea = 32'h2000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, ins_low_nz = 3'h0;
  logic        ins_valid = 1'h0, ins_tiny = 1'h0, ins_dp = 1'h0;
  logic        ins_hi_prio = 1'h0;
  logic [4:0]  ins_exc_set = 5'h0;
  logic [10:0] res_exp_out, e_s;
  fpa_class_e  ins_class = CL_OTHER;
  fpa_rng_e    ins_rng_a = RNG_NORM, ins_rng_b = RNG_NORM;
  fpa_rng_e    ins_rng_c = RNG_NORM;
  logic        assist_take, prog_take, dest_we, undef_result, a_s, w_s, u_s;
  int          n_mismatch = 0, checks = 0, cycles = 0, n_prog = 0, p0;
  fpa_row_s    rows [13] = '{
    '{CL_LD_S, RNG_D, 1'h0, 1'h0, 1'h1, 1'h0},
    '{CL_LD_S, RNG_E, 1'h0, 1'h0, 1'h0, 1'h0},
    '{CL_LD_D, RNG_B, 1'h0, 1'h0, 1'h0, 1'h0},
    '{CL_ST_S, RNG_D, 1'h0, 1'h0, 1'h1, 1'h0},
    '{CL_ST_S, RNG_B, 1'h0, 1'h0, 1'h0, 1'h1},
    '{CL_ST_D, RNG_F, 1'h0, 1'h0, 1'h0, 1'h0},
    '{CL_AR_S, RNG_E, 1'h1, 1'h0, 1'h0, 1'h1},
    '{CL_AR_S, RNG_D, 1'h0, 1'h0, 1'h0, 1'h0},
    '{CL_AR_D, RNG_B, 1'h0, 1'h0, 1'h1, 1'h0},
    '{CL_AR_D, RNG_C, 1'h0, 1'h0, 1'h0, 1'h0},
    '{CL_RND_S, RNG_B, 1'h0, 1'h0, 1'h1, 1'h0},
    '{CL_RND_S, RNG_C, 1'h0, 1'h1, 1'h1, 1'h0},
    '{CL_OTHER, RNG_F, 1'h0, 1'h0, 1'h0, 1'h0}};

  assign hready = hreadyout;  // single slave drives the bus ready

  fpa_assist_exc #(.EXP_W(11), .BASE_LO(32'h0), .BASE_HI(BASE_HI_T)) uut (
    .hclk(hclk), .hresetn(hresetn), .hce(1'h1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ins_valid(ins_valid),
    .ins_ea(ins_ea), .ins_class(ins_class), .ins_rng_a(ins_rng_a),
    .ins_rng_b(ins_rng_b), .ins_rng_c(ins_rng_c),
    .ins_low_nz(ins_low_nz), .ins_tiny(ins_tiny), .ins_dp(ins_dp),
    .ins_exc_set(ins_exc_set), .ins_hi_prio(ins_hi_prio),
    .ins_res_exp(11'h010), .rfi_valid(rfi_valid),
    .assist_take(assist_take), .prog_take(prog_take),
    .fetch_addr(fetch_addr), .dest_we(dest_we),
    .res_exp_out(res_exp_out), .undef_result(undef_result),
    .machine_state_out(msr_out));

  // ----------------------------------------------------------------
  // clock, program exception counter, hang guard
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (prog_take === 1'h1) n_prog <= n_prog + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end

  // compare one value, count and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one single ahb-lite transfer, read data left in rd
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  // one instruction pulse, registered answers captured after the edge
  task automatic op(input fpa_class_e c, input fpa_rng_e ra, rb,
                    input logic lz, tn, dp, input logic [4:0] ex,
                    input logic hp);
    @(posedge hclk);
    ea = ea + 32'h4;
    ins_ea      <= ea;
    ins_class   <= c;
    ins_rng_a   <= ra;
    ins_rng_b   <= rb;
    ins_rng_c   <= rb;
    ins_low_nz  <= {3{lz}};
    ins_tiny    <= tn;
    ins_dp      <= dp;
    ins_exc_set <= ex;
    ins_hi_prio <= hp;
    ins_valid   <= 1'h1;
    @(posedge hclk);
    ins_valid   <= 1'h0;
    #1;
    a_s = assist_take;
    w_s = dest_we;
    u_s = undef_result;
    e_s = res_exp_out;
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    // reset values, last offset is unmapped
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
    end
    // tiny result assist with vector select, check enable, endian copy
    bus(1'h1, OFF_MSR, 32'h0001_1048);
    op(CL_AR_D, RNG_NORM, RNG_NORM, 1'h0, 1'h1, 1'h1, 5'h0, 1'h0);
    chk(32'(a_s), 32'h1);
    chk(fetch_addr, BASE_HI_T + VEC_OFF);
    chk(msr_out, 32'h0000_1041);
    bus(1'h0, OFF_SAVE_RESTORE_PC, 32'h0);
    chk(rd, ea);
    bus(1'h0, OFF_SAVE_RESTORE_STATE, 32'h0);
    chk(rd, 32'h0000_1048);
    op(CL_AR_D, RNG_NORM, RNG_NORM, 1'h0, 1'h1, 1'h1, 5'h0, 1'h1);
    chk(32'(a_s), 32'h0);
    // enabled exception raised by an instruction
    bus(1'h1, OFF_MSR, 32'h0000_0800);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0000_0080);
    p0 = n_prog;
    op(CL_AR_D, RNG_NORM, RNG_NORM, 1'h0, 1'h0, 1'h1, 5'h10, 1'h0);
    chk(32'(a_s), 32'h1);
    chk(fetch_addr, VEC_OFF);
    bus(1'h0, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    chk(32'(rd[FS_FEX]), 32'h1);
    chk(32'(n_prog - p0), 32'h0);
    // condition made true by a state write, then by a return
    bus(1'h1, OFF_MSR, 32'h0000_0800);
    repeat (3) @(posedge hclk);
    chk(32'(n_prog - p0), 32'h1);
    bus(1'h1, OFF_MSR, 32'h0);
    bus(1'h1, OFF_SAVE_RESTORE_STATE, 32'h0000_0840);
    @(posedge hclk);
    rfi_valid <= 1'h1;
    @(posedge hclk);
    rfi_valid <= 1'h0;
    repeat (3) @(posedge hclk);
    chk(msr_out, 32'h0000_0840);
    chk(32'(n_prog - p0), 32'h2);
    bus(1'h1, OFF_MSR, 32'h0);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    // denormal partitioning table
    foreach (rows[i]) begin
      op(rows[i].c, rows[i].r, RNG_NORM, rows[i].lz, rows[i].tn, 1'h0,
         5'h0, 1'h0);
      chk(32'(a_s), 32'(rows[i].ast));
      chk(32'(u_s), 32'(rows[i].und));
      if (!rows[i].und) chk(32'(w_s), 32'(!rows[i].ast));
    end
    // underflow enabled: only round-to-single from a denormal assists
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0000_0020);
    op(CL_RND_S, RNG_C, RNG_NORM, 1'h0, 1'h1, 1'h0, 5'h0, 1'h0);
    chk(32'(a_s), 32'h1);
    op(CL_AR_D, RNG_NORM, RNG_NORM, 1'h0, 1'h1, 1'h1, 5'h0, 1'h0);
    chk(32'(a_s), 32'h0);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    // sync-ignore mode: no second assist, adjusted exponent, cause flags
    bus(1'h1, OFF_MSR, 32'h0);
    bus(1'h1, OFF_CAUSE, 32'h8000_0000);
    op(CL_AR_D, RNG_B, RNG_C, 1'h0, 1'h1, 1'h1, 5'h0, 1'h0);
    chk(32'(a_s), 32'h0);
    chk(32'(e_s), 32'(11'h010 + EXP_ADJ_D));
    bus(1'h0, OFF_CAUSE, 32'h0);
    chk(rd, 32'h8000_000F);
    bus(1'h0, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    chk(32'(rd[FS_UX]), 32'h0);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0800_0000);
    op(CL_AR_S, RNG_NORM, RNG_NORM, 1'h0, 1'h1, 1'h0, 5'h0, 1'h0);
    chk(32'(e_s), 32'(11'h010 + EXP_ADJ_S));
    bus(1'h1, OFF_MSR, 32'h0000_0800);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0000_0080);
    p0 = n_prog;
    op(CL_AR_D, RNG_NORM, RNG_NORM, 1'h0, 1'h0, 1'h1, 5'h10, 1'h0);
    chk(32'(a_s), 32'h0);
    bus(1'h0, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    chk(32'(rd[FS_FLG_HI]), 32'h1);
    chk(32'(n_prog - p0), 32'h1);
    bus(1'h1, OFF_FP_STATUS_CONTROL_REG, 32'h0);
    op(CL_LD_S, RNG_D, RNG_NORM, 1'h0, 1'h0, 1'h0, 5'h0, 1'h0);
    chk(32'(a_s), 32'h1);
    finish_test;
  end
endmodule // fpa_assist_exc_tb
